// *** design/status_event_filter_bank.sv ***
// Four status groups: three phase summary groups and the questionable group.
// Condition sources come from pins in other domains; they are synchronised.
`timescale 1ns/1ns

module status_event_filter_bank
  import status_filter_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      srst,
  input  wire status_filter_pkg::word_t  cond_src [status_filter_pkg::N_GROUP],
  input  wire logic                      inst_reset,
  input  wire logic                      clear_status,
  input  wire logic                      preset,
  input  wire logic                      wr_en,
  input  wire status_filter_pkg::group_t wr_group,
  input  wire status_filter_pkg::sel_e   wr_sel,
  input  wire status_filter_pkg::word_t  wr_data,
  input  wire logic                      rd_en,
  input  wire status_filter_pkg::group_t rd_group,
  input  wire status_filter_pkg::sel_e   rd_sel,
  output logic                           rd_valid,
  output status_filter_pkg::word_t       rd_data,
  output logic                           oper_summary,
  output logic                           ques_summary
);
  import status_filter_pkg::*;

  // ----------------------------------------
  // Condition synchronisers and history
  // ----------------------------------------
  word_t sync1 [N_GROUP];
  word_t cond  [N_GROUP];
  word_t prev  [N_GROUP];

  // Sync stage one only feeds stage two; live sources refill the condition
  // register every cycle, so an instrument reset keeps held conditions and
  // makes no false edge for the filters to catch
  always_ff @(posedge clk_sys) begin
    for (int g = 0; g < N_GROUP; g++) begin
      sync1[g] <= cond_src[g];
      if (srst) begin
        cond[g] <= '0;
      end else if (inst_reset) begin
        cond[g] <= sync1[g];
      end else begin
        cond[g] <= sync1[g];
      end
      prev[g] <= srst ? word_t'(0) : cond[g];
    end
  end

  // ----------------------------------------
  // Filters, masks and event registers
  // ----------------------------------------
  word_t rise   [N_GROUP];
  word_t fall   [N_GROUP];
  word_t enable [N_GROUP];
  word_t event_q[N_GROUP];
  word_t next_rise   [N_GROUP];
  word_t next_fall   [N_GROUP];
  word_t next_enable [N_GROUP];
  word_t next_event  [N_GROUP];

  function automatic word_t edge_hits(word_t now, word_t was,
                                      word_t r, word_t f);
    return (now & ~was & r)
         | (~now & was & f);
  endfunction : edge_hits

  always_comb begin
    for (int g = 0; g < N_GROUP; g++) begin
      next_rise[g]   = rise[g];
      next_fall[g]   = fall[g];
      next_enable[g] = enable[g];
      next_event[g]  = event_q[g];
      if (wr_en && wr_group == group_t'(g)) begin
        unique case (wr_sel)
          SEL_ENABLE: next_enable[g] = wr_data;
          SEL_RISE:   next_rise[g]   = wr_data;
          SEL_FALL:   next_fall[g]   = wr_data;
          default:    ;
        endcase
      end
      // Preset touches only masks and filters, never events
      if (preset) begin
        next_enable[g] = PRESET_EN;
        next_fall[g]   = PRESET_FALL;
        next_rise[g]   = PRESET_RISE;
      end
      // Read-clear and clear-status lose to a same-cycle edge
      if (clear_status) begin
        next_event[g] = '0;
      end
      if (rd_en && rd_group == group_t'(g) && rd_sel == SEL_EVENT) begin
        next_event[g] = '0;
      end
      // Instrument reset has no path here, so events hold
      next_event[g] = next_event[g]
        | edge_hits(cond[g], prev[g], rise[g], fall[g]);
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int g = 0; g < N_GROUP; g++) begin
      if (srst) begin
        rise[g]    <= RST_RISE;
        fall[g]    <= RST_FALL;
        enable[g]  <= RST_ENABLE;
        event_q[g] <= RST_EVENT;
      end else begin
        rise[g]    <= next_rise[g];
        fall[g]    <= next_fall[g];
        enable[g]  <= next_enable[g];
        event_q[g] <= next_event[g];
      end
    end
  end

  // ----------------------------------------
  // Query port and summaries
  // ----------------------------------------
  word_t next_rd_data;
  logic  next_oper;
  logic  next_ques;

  always_comb begin
    next_rd_data = rd_data;
    if (rd_en) begin
      unique case (rd_sel)
        SEL_COND:   next_rd_data = cond[rd_group];
        SEL_EVENT:  next_rd_data = event_q[rd_group];
        SEL_ENABLE: next_rd_data = enable[rd_group];
        SEL_RISE:   next_rd_data = rise[rd_group];
        SEL_FALL:   next_rd_data = fall[rd_group];
        default:    next_rd_data = '0;
      endcase
    end
    next_oper = 1'b0;
    for (int g = 0; g < 3; g++) begin
      next_oper = next_oper | (|(event_q[g] & enable[g]));
    end
    next_ques = |(event_q[GRP_QUES] & enable[GRP_QUES]);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data      <= '0;
      rd_valid     <= 1'b0;
      oper_summary <= 1'b0;
      ques_summary <= 1'b0;
    end else begin
      rd_data      <= next_rd_data;
      rd_valid     <= rd_en;
      oper_summary <= next_oper;
      ques_summary <= next_ques;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  chk_clear_status: assert property (
    clear_status && !preset && !(wr_en && wr_sel == SEL_ENABLE)
    |=> enable[0] == $past(enable[0]))
    else $error("clear status changed an enable mask");

  chk_rise_event: assert property (
    cond[0][0] && !prev[0][0] && rise[0][0] |=> event_q[0][0])
    else $error("rising edge not latched");

  chk_fall_event: assert property (
    !cond[1][0] && prev[1][0] && fall[1][0] |=> event_q[1][0])
    else $error("falling edge not latched");

  chk_no_filter: assert property (
    !rise[3][0] && !fall[3][0] && !event_q[3][0] && !clear_status
    |=> !event_q[3][0])
    else $error("unfiltered edge set event");

  chk_preset_vals: assert property (
    preset |=> rise[2] == PRESET_RISE && fall[2] == PRESET_FALL
               && enable[2] == PRESET_EN)
    else $error("preset values wrong");

  chk_preset_event: assert property (
    preset && !clear_status && !rd_en
    |=> event_q[3] == $past(event_q[3]
        | edge_hits(cond[3], prev[3], rise[3], fall[3])))
    else $error("preset cleared events");

  chk_read_clear: assert property (
    rd_en && rd_sel == SEL_EVENT && rd_group == GRP_QUES && !clear_status
    |=> rd_data == $past(event_q[3])
        && event_q[3] == $past(edge_hits(cond[3], prev[3], rise[3], fall[3])))
    else $error("event read did not return then clear");

  chk_inst_reset: assert property (
    inst_reset && cond[3] == prev[3] && cond[3] == sync1[3]
    && !clear_status && !rd_en
    |=> event_q[3] == $past(event_q[3]) && cond[3] == $past(cond[3]))
    else $error("instrument reset disturbed questionable events");

  chk_cond_reset: assert property (
    inst_reset |=> cond[0] == $past(sync1[0]))
    else $error("reset did not keep live conditions only");

  chk_ques_sum: assert property (
    |(event_q[3] & enable[3]) |=> ques_summary)
    else $error("questionable summary missing");

  // ----------------------------------------
  // Checks on filters, queries and masks
  // ----------------------------------------

  chk_both_filters: assert property (
    cond[2][1] != prev[2][1] && rise[2][1] && fall[2][1]
    |=> event_q[2][1])
    else $error("two-way filter missed an edge");

  chk_fall_ques: assert property (
    !cond[3][2] && prev[3][2] && fall[3][2] |=> event_q[3][2])
    else $error("questionable falling edge not latched");

  chk_rise_ques: assert property (
    cond[3][7] && !prev[3][7] && rise[3][7] |=> event_q[3][7])
    else $error("questionable rising edge not latched");

  chk_phase_unfiltered: assert property (
    !rise[0][15] && !fall[0][15] && !event_q[0][15]
    |=> !event_q[0][15])
    else $error("unfiltered phase edge set event");

  chk_clear_events: assert property (
    clear_status
    |=> event_q[1] == $past(edge_hits(cond[1], prev[1], rise[1], fall[1])))
    else $error("clear status left event bits");

  chk_clear_mask: assert property (
    clear_status && !preset && !wr_en |=> enable[3] == $past(enable[3]))
    else $error("clear status changed the questionable mask");

  chk_event_hold: assert property (
    !clear_status && !(rd_en && rd_sel == SEL_EVENT)
    |=> (event_q[2] & $past(event_q[2])) == $past(event_q[2]))
    else $error("latched event bit lost");

  chk_phase_read: assert property (
    rd_en && rd_sel == SEL_EVENT && rd_group == GRP_PHASE3 && !clear_status
    |=> rd_data == $past(event_q[2])
        && event_q[2] == $past(edge_hits(cond[2], prev[2], rise[2], fall[2])))
    else $error("phase event read did not return then clear");

  chk_event_write: assert property (
    wr_en && wr_sel == SEL_EVENT && !clear_status && !rd_en
    |=> event_q[1] == $past(event_q[1]
        | edge_hits(cond[1], prev[1], rise[1], fall[1])))
    else $error("event register took a write");

  chk_cond_query: assert property (
    rd_en && rd_sel == SEL_COND |=> rd_data == $past(cond[rd_group]))
    else $error("condition query wrong");

  chk_cond_write: assert property (
    wr_en && wr_sel == SEL_COND |=> cond[2] == $past(sync1[2]))
    else $error("condition register took a write");

  chk_cond_track: assert property (
    !inst_reset |=> cond[1] == $past(sync1[1]))
    else $error("condition does not follow source");

  chk_enable_query: assert property (
    rd_en && rd_sel == SEL_ENABLE |=> rd_data == $past(enable[rd_group]))
    else $error("enable query wrong");

  chk_rise_query: assert property (
    rd_en && rd_sel == SEL_RISE |=> rd_data == $past(rise[rd_group]))
    else $error("rising filter query wrong");

  chk_fall_query: assert property (
    rd_en && rd_sel == SEL_FALL |=> rd_data == $past(fall[rd_group]))
    else $error("falling filter query wrong");

  chk_read_valid: assert property (
    1'b1 |=> rd_valid == $past(rd_en))
    else $error("read valid not one cycle after request");

  chk_read_hold: assert property (
    !rd_en |=> rd_data == $past(rd_data))
    else $error("read data changed without a read");

  chk_mask_write: assert property (
    wr_en && wr_sel == SEL_ENABLE && wr_group == GRP_PHASE2 && !preset
    |=> enable[1] == $past(wr_data))
    else $error("enable write lost");

  chk_filter_write: assert property (
    wr_en && wr_sel == SEL_FALL && wr_group == GRP_QUES && !preset
    |=> fall[3] == $past(wr_data))
    else $error("falling filter write lost");

  chk_group_split: assert property (
    !preset && !(wr_en && wr_group == GRP_PHASE1)
    |=> enable[0] == $past(enable[0]) && rise[0] == $past(rise[0])
        && fall[0] == $past(fall[0]))
    else $error("phase one setting changed by another group");

  chk_oper_set: assert property (
    |(event_q[1] & enable[1]) |=> oper_summary)
    else $error("operation summary missing");

  chk_oper_mask: assert property (
    !(|(event_q[0] & enable[0])) && !(|(event_q[1] & enable[1]))
    && !(|(event_q[2] & enable[2])) |=> !oper_summary)
    else $error("operation summary without an enabled event");

  chk_ques_mask: assert property (
    !(|(event_q[3] & enable[3])) |=> !ques_summary)
    else $error("questionable summary without an enabled event");

  chk_edge_history: assert property (
    1'b1 |=> prev[2] == $past(cond[2]))
    else $error("edge history not one cycle old");

  chk_preset_ques: assert property (
    preset |=> rise[3] == PRESET_RISE && fall[3] == PRESET_FALL
               && enable[3] == PRESET_EN && enable[0] == PRESET_EN)
    else $error("preset values wrong in questionable group");

  chk_preset_other: assert property (
    preset && !rd_en
    |=> rd_data == $past(rd_data) && cond[0] == $past(sync1[0]))
    else $error("preset disturbed other state");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------

  cov_rise:   cover property (cond[0][0] && !prev[0][0] && rise[0][0]);
  cov_readc:  cover property (rd_en && rd_sel == SEL_EVENT && |event_q[3]);
  cov_preset: cover property (preset ##1 oper_summary == 1'b0);
  cov_sum:    cover property (oper_summary && ques_summary);
  cov_inst:   cover property (inst_reset && |cond[3]);

endmodule : status_event_filter_bank

// *** design/status_filter_pkg.sv ***
// Constants and types for the status event filter bank.
// Assumes one 10 MHz system clock and a synchronous active-high reset.
//
// Contract
// - Clear-status zeroes every event register, leaves enable masks alone.
// - Falling filter bit set: a 1-to-0 condition change sets event bit.
// - Rising filter bit set: a 0-to-1 condition change sets event bit.
// - Both filter bits set: any condition change sets the event bit.
// - Both filter bits clear: no condition change ever sets event bit.
// - Preset changes only masks and filters, never event registers.
// - Preset clears masks and falling filters, loads rising filters all ones.
// - Preset leaves every other status setting untouched.
// - Event register latches filtered events; a read returns then clears it.
// - Instrument reset leaves the questionable event register unchanged.
// - Condition read returns live status and modifies nothing.
// - Condition bits track their sources and drop when a source drops.
// - Instrument reset clears condition bits except conditions still true.
// - Queries return the binary-weighted value, bit n weighs two to n.
// - Masks and filters are written as weighted values, default zero.
// - Three independent per-phase summary groups selected by phase index.
// - Enabled phase event bits drive the operation summary bit.
// - Enabled questionable event bits drive the questionable summary bit.
package status_filter_pkg;

  localparam int REG_W   = 16;
  localparam int N_GROUP = 4;

  typedef logic [REG_W-1:0] word_t;
  typedef logic [1:0]       group_t;

  // Group indices: phases 1..3 at 0..2, questionable group at 3
  localparam group_t GRP_PHASE1 = 2'h0;
  localparam group_t GRP_PHASE2 = 2'h1;
  localparam group_t GRP_PHASE3 = 2'h2;
  localparam group_t GRP_QUES   = 2'h3;

  // Register selectors within a group
  typedef enum logic [2:0] {
    SEL_COND,
    SEL_EVENT,
    SEL_ENABLE,
    SEL_RISE,
    SEL_FALL
  } sel_e;

  localparam word_t RST_ENABLE   = 16'h0000;
  localparam word_t RST_FALL     = 16'h0000;
  localparam word_t RST_RISE     = 16'h0000;
  localparam word_t PRESET_EN    = 16'h0000;
  localparam word_t PRESET_FALL  = 16'h0000;
  localparam word_t PRESET_RISE  = 16'hFFFF;
  localparam word_t RST_EVENT    = 16'h0000;

endpackage : status_filter_pkg

// *** sim/status_event_filter_bank_test.sv ***
// Bench: random filters and conditions against an integer model.
// Assumes status_host drives all command strobes.
`timescale 1ns/1ns
module status_event_filter_bank_test;
  import status_filter_pkg::*;
  logic   clk_sys, srst, rd_valid, rd_en, wr_en, preset;
  logic   inst_reset, clear_status, oper_summary, ques_summary;
  group_t wr_group, rd_group;
  sel_e   wr_sel, rd_sel;
  word_t  wr_data, rd_data, src [N_GROUP];
  word_t  m [4][5];
  int     bad_count = 0, cmp_count = 0;
  logic [31:0] seed = 32'hDBA6;

  status_event_filter_bank i_dut (.clk_sys(clk_sys), .srst(srst),
    .cond_src(src), .inst_reset(inst_reset), .clear_status(clear_status),
    .preset(preset), .wr_en(wr_en), .wr_group(wr_group), .wr_sel(wr_sel),
    .wr_data(wr_data), .rd_en(rd_en), .rd_group(rd_group),
    .rd_sel(rd_sel), .rd_valid(rd_valid), .rd_data(rd_data),
    .oper_summary(oper_summary), .ques_summary(ques_summary));
  status_host i_host (.clk_sys(clk_sys), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_en(wr_en), .wr_group(wr_group), .wr_sel(wr_sel),
    .wr_data(wr_data), .rd_en(rd_en), .rd_group(rd_group), .rd_sel(rd_sel),
    .inst_reset(inst_reset), .clear_status(clear_status), .preset(preset));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Model m[group][selector], same coding as the bank
  // ----------------------------------------
  function automatic word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp_word(input word_t e, input word_t g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic e, input logic g);
    cmp_word({15'h0000, e}, {15'h0000, g});
  endtask : cmp_bit

  task automatic put(input int g, input int s, input word_t v);
    m[g][s] = v;
    i_host.wr(group_t'(g), sel_e'(s), v);
  endtask : put

  // Reads every register; an event read empties the model copy too
  task automatic chk_all();
    word_t d;
    bit    ok;
    for (int g = 0; g < 4; g++) begin
      for (int s = 0; s < 5; s++) begin
        i_host.rd(group_t'(g), sel_e'(s), d, ok);
        if (!ok) begin
          bad_count++;
          tally_and_finish();
        end else begin
          cmp_word(m[g][s], d);
        end
        if (s == 1) m[g][1] = 16'h0000;
      end
    end
  endtask : chk_all

  // Mode 0 random, 1 fixed value, 2 hold; one change per settle window
  task automatic step(input int mode, input word_t v);
    word_t nw;
    @(negedge clk_sys);
    for (int g = 0; g < 4; g++) begin
      nw = (mode == 0) ? rnd() : (mode == 1) ? v : m[g][0];
      m[g][1] |= m[g][3] & ~m[g][0] & nw | m[g][4] & m[g][0] & ~nw;
      m[g][0] = nw;
      src[g] = nw;
    end
    repeat (6) @(negedge clk_sys);
    cmp_bit(|(m[0][1] & m[0][2] | m[1][1] & m[1][2] | m[2][1] & m[2][2]),
            oper_summary);
    cmp_bit(|(m[3][1] & m[3][2]), ques_summary);
  endtask : step

  initial begin
    srst = 1'b1;
    foreach (m[g, s]) m[g][s] = 16'h0000;
    foreach (src[g]) src[g] = 16'h0000;
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    chk_all();
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 12; i++) put(i / 3, i % 3 + 2, rnd());
      step(0, 16'h0000);
      if (k % 2 == 1) chk_all();
    end
    step(0, 16'h0000);
    i_host.pulse(1);
    foreach (m[g]) m[g][1] = 16'h0000;
    step(2, 16'h0000);
    chk_all();
    step(0, 16'h0000);
    i_host.pulse(2);
    foreach (m[g]) begin
      m[g][2] = 16'h0000;
      m[g][3] = 16'hFFFF;
      m[g][4] = 16'h0000;
    end
    chk_all();
    step(0, 16'h0000);
    for (int g = 0; g < 4; g++) begin
      put(g, 3, (g == 3) ? 16'hFFFF : 16'h0000);
      i_host.wr(group_t'(g), sel_e'(g % 2), 16'hFFFF);
    end
    step(1, 16'hFFFF);
    chk_all();
    i_host.pulse(0);
    step(2, 16'h0000);
    chk_all();
    tally_and_finish();
  end
endmodule : status_event_filter_bank_test

// *** sim/status_host.sv ***
// Host model: sends status commands as one-cycle strobes.
// Assumes the bank takes every strobe on the rising edge of clk_sys.
`timescale 1ns/1ns
module status_host
  import status_filter_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rd_valid,
  input  wire status_filter_pkg::word_t rd_data,
  output logic                          wr_en,
  output status_filter_pkg::group_t     wr_group,
  output status_filter_pkg::sel_e       wr_sel,
  output status_filter_pkg::word_t      wr_data,
  output logic                          rd_en,
  output status_filter_pkg::group_t     rd_group,
  output status_filter_pkg::sel_e       rd_sel,
  output logic                          inst_reset,
  output logic                          clear_status,
  output logic                          preset
);
  // ----------------------------------------
  // Command tasks
  // ----------------------------------------
  initial begin
    {wr_en, rd_en, inst_reset, clear_status, preset} = 5'h00;
    {wr_group, rd_group, wr_data} = 20'h00000;
    wr_sel = SEL_COND;
    rd_sel = SEL_COND;
  end

  // Word is weighted, bit n worth two to n
  task automatic wr(input group_t g, input sel_e s, input word_t d);
    @(negedge clk_sys);
    wr_en    = 1'b1;
    wr_group = g;
    wr_sel   = s;
    wr_data  = d;
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask : wr

  // Bounded wait, so a silent bank cannot hang the run
  task automatic rd(input group_t g, input sel_e s,
                    output word_t d, output bit ok);
    @(negedge clk_sys);
    rd_en    = 1'b1;
    rd_group = g;
    rd_sel   = s;
    @(negedge clk_sys);
    rd_en = 1'b0;
    for (int n = 0; n < 4 && rd_valid !== 1'b1; n++) begin
      @(negedge clk_sys);
    end
    ok = (rd_valid === 1'b1);
    d  = rd_data;
  endtask : rd

  // Pulse select: 0 instrument reset, 1 clear, 2 preset
  task automatic pulse(input int k);
    @(negedge clk_sys);
    {inst_reset, clear_status, preset} = 3'h4 >> k;
    @(negedge clk_sys);
    {inst_reset, clear_status, preset} = 3'h0;
  endtask : pulse
endmodule : status_host
